// ==== common/fci_pkg.sv ====
// shared constants and carrier types for the flight computer instruction control block
package fci_pkg;
    // stored word: parity in bit 15, sign in bit 14, magnitude in bits 13..0
    localparam int DW = 15;
    localparam int AW = 12;
    // fixed start, interrupt vector and counter base locations
    localparam logic [11:0] ADDR_GO = 12'h800;
    localparam logic [11:0] INT_VEC_BASE = 12'h810;
    localparam logic [11:0] CNT_BASE = 12'h020;
    // order code register and stage counter presets
    localparam logic [6:0] SQ_INT = 7'h47;
    localparam logic [6:0] SQ_CLR = 7'h00;
    localparam logic [2:0] ST_INT = 3'h0;
    localparam logic [2:0] ST_START = 3'h1;
    localparam logic [2:0] ST_GOTO = 3'h3;
    localparam logic [2:0] ST_OPER = 3'h1;
    localparam logic [2:0] ST_STORE = 3'h2;
    // basic order codes
    localparam logic [2:0] ORD_TC = 3'h0;
    localparam logic [2:0] ORD_CA = 3'h3;
    localparam logic [2:0] ORD_TS = 3'h5;
    localparam logic [2:0] ORD_AD = 3'h6;
    // special addresses used with order code 0
    localparam logic [11:0] SP_EXTEND = 12'h006;
    localparam logic [11:0] SP_SWINT = 12'h007;
    localparam logic [11:0] SP_RESUME = 12'h00f;
    // extended order codes and channel quarter codes
    localparam logic [2:0] EXT_CHAN = 3'h0;
    localparam logic [2:0] EXT_SU = 3'h6;
    localparam logic [2:0] QC_RDCH = 3'h0;
    localparam logic [2:0] QC_WRCH = 3'h1;
    // interrupt sources, lowest index wins
    localparam int NINT = 4;
    localparam int INT_TIMER = 0;
    localparam int INT_TLM = 1;
    localparam int INT_KEY = 2;
    localparam int INT_SW = 3;
    // register offsets and reset values
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_GOTO = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam logic [11:0] REG_ACC = 12'h00c;
    localparam logic [11:0] REG_ERR = 12'h010;
    localparam logic [11:0] REG_KEY = 12'h014;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_INTEN_BIT = 1;

    typedef struct packed {
        logic req;
        logic we;
        logic [11:0] addr;
        logic [15:0] wdata;
    } fci_mem_req_s;
endpackage : fci_pkg

// ==== hw/fci_parity.sv ====
// odd parity generator and checker for one memory word
`timescale 1ns/1ps
module fci_parity #(
    parameter int W = 15
) (
    // word under test
    input wire logic [W-1:0] data,
    input wire logic parIn,
    // results
    output logic parGen,
    output logic parBad
);
    // generated bit makes the total count of ones odd
    assign parGen = ~(^data);
    assign parBad = ~(^{parIn, data});
endmodule : fci_parity

// ==== hw/fci_top.sv ====
// instruction sequencing, priority control and counter service of the flight computer
// What this block does
// - top three address bits extend the order code for selected instructions
// - erasable-only instructions drop the two top address bits; fixed ones keep all
// - special instructions are recognised by order code plus fixed address
// - one special instruction sets extend mode for the next instruction word
// - channel instructions touch only channels; extracodes do rarer arithmetic
// - interrupts get order code and address from logic in basic word layout
// - counter requests pick the operation; logic supplies one of 29 counter addresses
// - one interrupt starts the machine at power-up and traps; another runs periodically
// - program can invoke a separate software interrupt (INT_SW), not the periodic one, to test the machine
// - counters step by one in ones-complement or in twos-complement
// - next instruction address is current address plus one
// - instruction ends when next order code and address are held
// - ones-complement arithmetic on 14 bits plus sign with an overflow bit
// - check parity on every memory read, generate it on every write
// - parity is odd over the stored word
// - each incremental pulse makes a counter address and priority request
// - counter service writes the address to memory and updates its contents
// - main time counter is fed by timer pulses and spans 745.65 hours
// - telemetry end pulses raise a priority request
// - a key press latches the keycode and raises the keypad request
// - interrupt sets the order code to 1000111; start and goto clear it
// - stage preset: interrupt 000, start 001, goto 011
// - interrupts and counter work win over regular instructions
// - words are 16 bits; bit 15 uncorrected sign, bit 16 true sign
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module fci_top #(
    parameter int NCNT = 29,
    parameter logic [28:0] TWOS_MASK = 29'h0000_0003
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory port
    output fci_pkg::fci_mem_req_s memOut,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    // input/output channels
    output logic [8:0] chanAddr,
    output logic [14:0] chanWdata,
    output logic chanWr,
    input wire logic [14:0] chanRdata,
    // incremental pulse sources
    input wire logic [NCNT-1:0] cntUp,
    input wire logic [NCNT-1:0] cntDn,
    input wire logic timerTick,
    input wire logic tlmEnd,
    input wire logic keyStrobe,
    input wire logic [4:0] keyCode,
    input wire logic trap,
    // status
    output logic parityErr,
    output logic overflow,
    output logic [4:0] keyData
);
    typedef enum logic [2:0] {S_NEXT, S_FETCH, S_EXEC, S_RD, S_WR, S_CRD, S_CWR} fci_state_e;

    fci_state_e state_reg;
    logic [15:0] acc_reg;
    logic [11:0] pc_reg, addr_reg, intRet_reg, goto_reg;
    logic [6:0] sq_reg;
    logic [2:0] stage_reg;
    logic extMode_reg, run_reg, intEn_reg, inInt_reg, startPend_reg, gotoPend_reg;
    logic [NCNT-1:0] pendUp_reg, pendDn_reg;
    logic [fci_pkg::NINT-1:0] intPend_reg;
    logic [4:0] cntIdx_reg;
    logic cntDir_reg, errSticky_reg;
    logic [15:0] cntVal_reg;

    // bus decode
    wire busWr = psel && penable && pready && pwrite;
    wire hitCtrl = (paddr == fci_pkg::REG_CTRL);
    wire hitGoto = (paddr == fci_pkg::REG_GOTO);
    wire hitStat = (paddr == fci_pkg::REG_STAT);
    wire hitAcc = (paddr == fci_pkg::REG_ACC);
    wire hitErr = (paddr == fci_pkg::REG_ERR);
    wire hitKey = (paddr == fci_pkg::REG_KEY);
    wire hitAny = hitCtrl || hitGoto || hitStat || hitAcc || hitErr || hitKey;
    wire [31:0] rdSel;
    assign rdSel = hitCtrl ? {30'h0, intEn_reg, run_reg} :
                   hitGoto ? {20'h0, goto_reg} :
                   hitStat ? {5'h0, state_reg, stage_reg, sq_reg, pc_reg, extMode_reg, inInt_reg} :
                   hitAcc ? {16'h0, acc_reg} :
                   hitErr ? {31'h0, errSticky_reg} :
                   hitKey ? {27'h0, keyData} : 32'h0;

    // parity on the read path and on the write path
    logic rdBad, rdGen, wrGen, wrBad;
    logic [14:0] wrWord;
    fci_parity #(.W(fci_pkg::DW)) uChk (
        .data(memRdata[14:0]), .parIn(memRdata[15]), .parGen(rdGen), .parBad(rdBad));
    fci_parity #(.W(fci_pkg::DW)) uGen (
        .data(wrWord), .parIn(1'b0), .parGen(wrGen), .parBad(wrBad));
    wire readDone = memOut.req && !memOut.we && memAck;

    // instruction fields
    wire [2:0] ord = memRdata[14:12];
    wire [11:0] fAddr = memRdata[11:0];
    wire [2:0] qc = memRdata[11:9];
    wire isSpecial = (ord == fci_pkg::ORD_TC) && !extMode_reg;
    wire isExtend = isSpecial && (fAddr == fci_pkg::SP_EXTEND);
    wire isSwInt = isSpecial && (fAddr == fci_pkg::SP_SWINT);
    wire isResume = isSpecial && (fAddr == fci_pkg::SP_RESUME);
    wire isErasable = (ord == fci_pkg::ORD_TS) && !extMode_reg;

    // ones-complement add with end-around carry on the 16-bit internal form
    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        oc_add = s[15:0] + {15'h0, s[16]};
    endfunction : oc_add
    function automatic logic [15:0] widen(input logic [14:0] w);
        widen = {w[14], w};
    endfunction : widen
    wire [15:0] opWide = widen(memRdata[14:0]);
    wire [15:0] sumAd = oc_add(acc_reg, opWide);
    wire [15:0] sumSu = oc_add(acc_reg, ~opWide);
    wire ovfAd = sumAd[15] ^ sumAd[14];
    wire ovfSu = sumSu[15] ^ sumSu[14];

    // counter arbitration, lowest pending index first
    wire [NCNT-1:0] pendAny = pendUp_reg | pendDn_reg;
    logic [4:0] cntPick;
    always_comb begin
        cntPick = 5'h0;
        for (int i = NCNT - 1; i >= 0; i--) begin
            if (pendAny[i]) begin
                cntPick = 5'(i);
            end
        end
    end
    logic [1:0] intPick;
    always_comb begin
        intPick = 2'h0;
        for (int i = fci_pkg::NINT - 1; i >= 0; i--) begin
            if (intPend_reg[i]) begin
                intPick = 2'(i);
            end
        end
    end

    // counter update arithmetic
    wire twos = TWOS_MASK[cntIdx_reg];
    wire [15:0] cntWide = widen(memRdata[14:0]);
    wire [15:0] ocStep = oc_add(cntWide, cntDir_reg ? 16'hfffe : 16'h0001);
    wire [14:0] tcStep = cntDir_reg ? memRdata[14:0] - 15'h1 : memRdata[14:0] + 15'h1;
    wire [14:0] cntNew = twos ? tcStep : {ocStep[15], ocStep[13:0]};
    // time counter low word carries into the next location at wrap
    wire timeCarry = (cntIdx_reg == 5'h0) && !cntDir_reg && (memRdata[13:0] == 14'h3fff);
    assign wrWord = (state_reg == S_CRD) ? (timeCarry ? 15'h0 : cntNew) : {acc_reg[15], acc_reg[13:0]};

    wire [NCNT-1:0] cntClr = (state_reg == S_NEXT && |pendAny && !startPend_reg && !gotoPend_reg)
                             ? (NCNT'(1) << cntPick) : '0;
    wire [NCNT-1:0] carrySet = (state_reg == S_CRD && memAck && timeCarry) ? NCNT'(2) : '0;
    wire [fci_pkg::NINT-1:0] intSet = {
        (state_reg == S_FETCH) && readDone && isSwInt, keyStrobe, tlmEnd, timerTick};
    wire takeInt = state_reg == S_NEXT && !startPend_reg && !gotoPend_reg && !(|pendAny)
                   && |intPend_reg && intEn_reg && !inInt_reg && run_reg;
    wire [fci_pkg::NINT-1:0] intClr = takeInt ? (fci_pkg::NINT'(1) << intPick) : '0;

    // register bus slave, zero wait states
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hitAny;
            prdata <= (psel && !penable && !pwrite) ? rdSel : 32'h0;
        end
    end

    // request latches; a new event wins over its own clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pendUp_reg <= '0;
            pendDn_reg <= '0;
            intPend_reg <= '0;
            keyData <= 5'h0;
        end else begin
            pendUp_reg <= (pendUp_reg & ~cntClr) | cntUp | carrySet;
            pendDn_reg <= (pendDn_reg & ~cntClr) | cntDn;
            intPend_reg <= (intPend_reg & ~intClr) | intSet;
            if (keyStrobe) begin
                keyData <= keyCode;
            end
        end
    end

    // software control and error status
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_reg <= fci_pkg::CTRL_RUN_RST;
            intEn_reg <= 1'b1;
            goto_reg <= fci_pkg::ADDR_GO;
            errSticky_reg <= 1'b0;
            parityErr <= 1'b0;
        end else begin
            parityErr <= readDone && rdBad;
            if (readDone && rdBad) begin
                errSticky_reg <= 1'b1;
            end else if (busWr && hitErr && pwdata[0]) begin
                errSticky_reg <= 1'b0;
            end
            if (busWr && hitCtrl) begin
                run_reg <= pwdata[fci_pkg::CTRL_RUN_BIT];
                intEn_reg <= pwdata[fci_pkg::CTRL_INTEN_BIT];
            end
            if (busWr && hitGoto) begin
                goto_reg <= pwdata[11:0];
            end
        end
    end

    // sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_NEXT;
            pc_reg <= fci_pkg::ADDR_GO;
            sq_reg <= fci_pkg::SQ_CLR;
            stage_reg <= fci_pkg::ST_START;
            startPend_reg <= 1'b0;
            gotoPend_reg <= 1'b0;
            extMode_reg <= 1'b0;
            inInt_reg <= 1'b0;
            intRet_reg <= 12'h0;
            addr_reg <= 12'h0;
            acc_reg <= 16'h0;
            overflow <= 1'b0;
            memOut <= '0;
            cntIdx_reg <= 5'h0;
            cntDir_reg <= 1'b0;
            cntVal_reg <= 16'h0;
            chanAddr <= 9'h0;
            chanWdata <= 15'h0;
            chanWr <= 1'b0;
        end else begin
            chanWr <= 1'b0;
            if (trap) begin
                startPend_reg <= 1'b1;
            end
            if (busWr && hitGoto) begin
                gotoPend_reg <= 1'b1;
            end
            case (state_reg)
                S_NEXT: begin
                    // boundary: only here may priority work break in
                    if (startPend_reg && !trap) begin
                        startPend_reg <= 1'b0;
                        sq_reg <= fci_pkg::SQ_CLR;
                        stage_reg <= fci_pkg::ST_START;
                        pc_reg <= fci_pkg::ADDR_GO;
                        extMode_reg <= 1'b0;
                        inInt_reg <= 1'b0;
                    end else if (gotoPend_reg && !(busWr && hitGoto)) begin
                        gotoPend_reg <= 1'b0;
                        sq_reg <= fci_pkg::SQ_CLR;
                        stage_reg <= fci_pkg::ST_GOTO;
                        pc_reg <= goto_reg;
                    end else if (|pendAny) begin
                        cntIdx_reg <= cntPick;
                        cntDir_reg <= !pendUp_reg[cntPick];
                        memOut.req <= 1'b1;
                        memOut.we <= 1'b0;
                        memOut.addr <= fci_pkg::CNT_BASE + {7'h0, cntPick};
                        state_reg <= S_CRD;
                    end else if (takeInt) begin
                        sq_reg <= fci_pkg::SQ_INT;
                        stage_reg <= fci_pkg::ST_INT;
                        intRet_reg <= pc_reg;
                        inInt_reg <= 1'b1;
                        pc_reg <= fci_pkg::INT_VEC_BASE + {8'h0, intPick, 2'b00};
                    end else if (run_reg) begin
                        memOut.req <= 1'b1;
                        memOut.we <= 1'b0;
                        memOut.addr <= pc_reg;
                        state_reg <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (memAck) begin
                        memOut.req <= 1'b0;
                        pc_reg <= pc_reg + 12'h1;
                        sq_reg <= {extMode_reg, ord, qc};
                        stage_reg <= 3'h0;
                        extMode_reg <= isExtend;
                        addr_reg <= isErasable ? {2'b00, fAddr[9:0]} : fAddr;
                        state_reg <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state_reg <= S_NEXT;
                    if (!sq_reg[6] && sq_reg[5:3] == fci_pkg::ORD_TC) begin
                        if (addr_reg == fci_pkg::SP_RESUME) begin
                            pc_reg <= intRet_reg;
                            inInt_reg <= 1'b0;
                        end else if (addr_reg != fci_pkg::SP_EXTEND && addr_reg != fci_pkg::SP_SWINT) begin
                            pc_reg <= addr_reg;
                        end
                    end else if (sq_reg[6] && sq_reg[5:3] == fci_pkg::EXT_CHAN) begin
                        chanAddr <= addr_reg[8:0];
                        if (sq_reg[2:0] == fci_pkg::QC_WRCH) begin
                            chanWdata <= {acc_reg[15], acc_reg[13:0]};
                            chanWr <= 1'b1;
                        end else if (sq_reg[2:0] == fci_pkg::QC_RDCH) begin
                            acc_reg <= widen(chanRdata);
                        end
                    end else if (!sq_reg[6] && sq_reg[5:3] == fci_pkg::ORD_TS) begin
                        stage_reg <= fci_pkg::ST_STORE;
                        memOut <= '{req: 1'b1, we: 1'b1, addr: addr_reg, wdata: 16'h0};
                        state_reg <= S_WR;
                    end else begin
                        stage_reg <= fci_pkg::ST_OPER;
                        memOut.req <= 1'b1;
                        memOut.we <= 1'b0;
                        memOut.addr <= addr_reg;
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    if (memAck) begin
                        memOut.req <= 1'b0;
                        state_reg <= S_NEXT;
                        if (sq_reg[6] && sq_reg[5:3] == fci_pkg::EXT_SU) begin
                            acc_reg <= sumSu;
                            overflow <= ovfSu;
                        end else if (!sq_reg[6] && sq_reg[5:3] == fci_pkg::ORD_AD) begin
                            acc_reg <= sumAd;
                            overflow <= ovfAd;
                        end else if (!sq_reg[6] && sq_reg[5:3] == fci_pkg::ORD_CA) begin
                            acc_reg <= opWide;
                        end
                    end
                end
                S_WR: begin
                    memOut.wdata <= {wrGen, wrWord};
                    if (memAck) begin
                        memOut.req <= 1'b0;
                        state_reg <= S_NEXT;
                    end
                end
                S_CRD: begin
                    if (memAck) begin
                        cntVal_reg <= {wrGen, wrWord};
                        memOut <= '{req: 1'b1, we: 1'b1, addr: memOut.addr,
                                    wdata: {wrGen, wrWord}};
                        state_reg <= S_CWR;
                    end
                end
                S_CWR: begin
                    if (memAck) begin
                        memOut.req <= 1'b0;
                        state_reg <= S_NEXT;
                    end
                end
                default: state_reg <= S_NEXT;
            endcase
        end
    end
endmodule : fci_top

// ==== verif/fci_mem_model.sv ====
// memory partner: answers after a programmable number of cycles
`timescale 1ns/1ps
module fci_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // memory port
    input wire fci_pkg::fci_mem_req_s memOut,
    input wire logic [3:0] memLat,
    output logic memAck,
    output logic [15:0] memRdata
);
    logic [15:0] mem [0:4095];
    int waitCnt;
    // read data toggles outside an answer so a stale word never looks fresh
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            memAck <= 1'b0;
            waitCnt <= 0;
            memRdata <= 16'h0000;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memOut.req && !memAck) begin
                // writes wait two cycles at least, wdata settles late
                if (waitCnt >= memLat && (!memOut.we || waitCnt >= 2)) begin
                    memAck <= 1'b1;
                    waitCnt <= 0;
                    if (memOut.we) mem[memOut.addr] <= memOut.wdata;
                    else memRdata <= mem[memOut.addr];
                end else begin
                    waitCnt <= waitCnt + 1;
                end
            end
        end
    end
endmodule : fci_mem_model

// ==== verif/fci_top_monitor.sv ====
// port assertions for the instruction control block
`timescale 1ns/1ps
module fci_top_monitor #(
    parameter int NCNT = 29
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // memory and keypad
    input wire fci_pkg::fci_mem_req_s memOut,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    input wire logic keyStrobe,
    input wire logic [4:0] keyCode,
    input wire logic [4:0] keyData,
    input wire logic parityErr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic cntHit;
    assign cntHit = memOut.addr >= fci_pkg::CNT_BASE && memOut.addr < fci_pkg::CNT_BASE + NCNT;
    property p_wr_odd; memOut.req && memOut.we && memAck |-> ^memOut.wdata; endproperty
    a_wr_odd: assert property (p_wr_odd) else $error("written word has even parity");
    property p_rd_bad; memAck && !memOut.we && !(^memRdata) |=> parityErr; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("bad read parity not flagged");
    property p_err_cause;
        parityErr |-> $past(memAck) && !$past(memOut.we) && !(^$past(memRdata));
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("parity error without cause");
    property p_hold; memOut.req && !memAck |=> memOut.req && $stable(memOut.addr); endproperty
    a_hold: assert property (p_hold) else $error("memory request dropped early");
    property p_rmw; memAck && !memOut.we && cntHit |=> memOut.req && memOut.we && $stable(memOut.addr);
    endproperty
    a_rmw: assert property (p_rmw) else $error("counter read not followed by write");
    property p_wr_end; memAck && memOut.we |=> !memOut.req; endproperty
    a_wr_end: assert property (p_wr_end) else $error("request held after write answer");
    property p_key; keyStrobe |=> keyData == $past(keyCode); endproperty
    a_key: assert property (p_key) else $error("keycode not latched");
    property p_apb; psel && !penable |=> pready; endproperty
    a_apb: assert property (p_apb) else $error("no ready after setup");
    property p_slverr; pslverr |-> pready; endproperty
    a_slverr: assert property (p_slverr) else $error("slave error without ready");
    c_cnt_wr: cover property (memAck && memOut.we && cntHit);
    c_perr: cover property (parityErr);
    c_key: cover property (keyStrobe);
endmodule : fci_top_monitor

bind fci_top fci_top_monitor #(.NCNT(NCNT)) u_mon (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .memOut(memOut),
    .memAck(memAck), .memRdata(memRdata), .keyStrobe(keyStrobe), .keyCode(keyCode),
    .keyData(keyData), .parityErr(parityErr));

// ==== verif/flight_computer_instruction_control_tb.sv ====
// self-checking testbench of the instruction control block
`timescale 1ns/1ps
module flight_computer_instruction_control_tb;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, memAck, chanWr;
    logic keyStrobe, parityErr, overflow, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] memRdata;
    logic [8:0] chanAddr;
    logic [14:0] chanWdata;
    logic [28:0] cntUp, cntDn;
    logic [4:0] keyCode, keyData;
    logic [3:0] memLat;
    fci_pkg::fci_mem_req_s memOut;
    int failures = 0;
    int n_tests = 0;

    fci_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memOut(memOut), .memAck(memAck), .memRdata(memRdata), .chanAddr(chanAddr),
        .chanWdata(chanWdata), .chanWr(chanWr), .chanRdata(15'h0000), .cntUp(cntUp),
        .cntDn(cntDn), .timerTick(1'b0), .tlmEnd(1'b0), .keyStrobe(keyStrobe),
        .keyCode(keyCode), .trap(1'b0), .parityErr(parityErr), .overflow(overflow),
        .keyData(keyData));
    fci_mem_model mdl (.core_clk(core_clk), .rst(rst), .memOut(memOut), .memLat(memLat),
        .memAck(memAck), .memRdata(memRdata));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [15:0] pw(input logic [14:0] v);
        return {~^v, v};
    endfunction : pw

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 20, 1);
    endtask : apb

    task automatic waitFetch(input logic [11:0] a);
        int n = 0;
        while (!(memOut.req === 1'b1 && memOut.we === 1'b0 && memOut.addr === a) && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 3000, 1);
    endtask : waitFetch

    task automatic waitMem(input logic [11:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        while (mdl.mem[a] !== exp && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk(mdl.mem[a], exp);
    endtask : waitMem

    task automatic t_regs();
        apb(1'b0, fci_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h018, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
    endtask : t_regs

    task automatic t_count();
        memLat <= 4'h5;
        @(posedge core_clk);
        cntUp <= 29'h1;
        cntDn <= 29'h4;
        @(posedge core_clk);
        cntUp <= 29'h0;
        cntDn <= 29'h0;
        waitMem(12'h020, pw(15'h0000));
        waitMem(12'h021, pw(15'h0002));
        waitMem(12'h022, pw(15'h0004));
    endtask : t_count

    task automatic t_parity();
        int n;
        n = 0;
        mdl.mem[12'h803] = pw({fci_pkg::ORD_TC, 12'h803}) ^ 16'h8000;
        while (parityErr !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 200, 1);
        mdl.mem[12'h803] = pw({fci_pkg::ORD_TC, 12'h803});
        apb(1'b0, fci_pkg::REG_ERR, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, fci_pkg::REG_ERR, 32'h1);
        apb(1'b0, fci_pkg::REG_ERR, 32'h0);
        chk(rd, 32'h0);
    endtask : t_parity

    task automatic t_flow();
        apb(1'b1, fci_pkg::REG_GOTO, 32'h805);
        waitFetch(12'h805);
        waitFetch(fci_pkg::INT_VEC_BASE + 12'hc);
        waitFetch(12'h806);
        @(posedge core_clk);
        keyStrobe <= 1'b1;
        keyCode <= 5'h15;
        @(posedge core_clk);
        keyStrobe <= 1'b0;
        waitFetch(fci_pkg::INT_VEC_BASE + 12'h8);
        chk(keyData, 5'h15);
        apb(1'b0, fci_pkg::REG_KEY, 32'h0);
        chk(rd, 32'h15);
    endtask : t_flow

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #60000;
        failures++;
        end_of_test();
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, cntUp, cntDn, keyStrobe, keyCode} = '0;
        rst = 1'b1;
        memLat = 4'h2;
        for (int i = 0; i < 4096; i++) mdl.mem[i] = pw(15'h0000);
        mdl.mem[12'h800] = pw({fci_pkg::ORD_CA, 12'h100});
        mdl.mem[12'h801] = pw({fci_pkg::ORD_AD, 12'h101});
        // erasable-only store: the two top address bits must be dropped
        mdl.mem[12'h802] = pw({fci_pkg::ORD_TS, 12'hd02});
        mdl.mem[12'h803] = pw({fci_pkg::ORD_TC, 12'h803});
        mdl.mem[12'h805] = pw({fci_pkg::ORD_TC, fci_pkg::SP_SWINT});
        mdl.mem[12'h806] = pw({fci_pkg::ORD_TC, 12'h806});
        mdl.mem[12'h81c] = pw({fci_pkg::ORD_TC, fci_pkg::SP_RESUME});
        mdl.mem[12'h818] = pw({fci_pkg::ORD_TC, 12'h818});
        mdl.mem[12'h100] = pw(15'h0005);
        mdl.mem[12'h101] = pw(15'h0007);
        mdl.mem[12'h020] = pw(15'h3fff);
        mdl.mem[12'h021] = pw(15'h0001);
        mdl.mem[12'h022] = pw(15'h0005);
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        waitMem(12'h102, pw(15'h000c));
        chk(overflow, 1'b0);
        t_count();
        t_parity();
        t_flow();
        end_of_test();
    end
endmodule : flight_computer_instruction_control_tb
